// file: hw/adc_limit_and_fault_mask_regs.sv
/*
 * Register bank: ADC window limits, interface mode select and the
 * alarm and general fault masks, with the masked summary outputs.
 * Assumes the serial front end hands over decoded one-cycle read and
 * write strobes with a register address, and that the fault sources
 * and conversion results arrive synchronous to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
// How it works
// (R1) High limit of input A gains four low ones; result above it faults
// (R2) Low limit of input A gains four low zeros; result below it faults
// (R3) Input B uses the same widened window with its own register
// (R4) Die temperature uses the same widened window with its register
// (R5) Limit registers reset high field all ones, low field zero
// (R6) Mode bit zero gives the map to SPI, one to break port
// (R7) Mode register only written from the break port
// (R8) Masked fault drives neither interrupt nor alarm
// (R9) Status bits follow the fault whatever the mask
// (R10) Alarm mask resets EFDF: oscillator and reference unmasked
// (R11) Alarm mask bit positions 13,8,7,6,4,3,2 as listed
// (R12) Overtemperature error bit 1, warning bit 0, both reset one
// (R13) General mask: slew complete bit 7, conversion complete bit 6
// (R14) General mask bits 3..0 break and async errors, reset FFFF
// (R15) Alarm summary is OR of unmasked alarm status bits
// (R16) Input A fault yields the two-bit action from its field
// (R17) Each channel compared when its new conversion result completes
module adc_limit_and_fault_mask_regs (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        reg_write_in,
	input  wire logic        reg_read_in,
	input  wire logic        from_break_port_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic [11:0] input_a_result_in,
	input  wire logic        input_a_done_in,
	input  wire logic [11:0] input_b_result_in,
	input  wire logic        input_b_done_in,
	input  wire logic [11:0] temp_result_in,
	input  wire logic        temp_done_in,
	input  wire logic [1:0]  input_a_action_in,
	input  wire logic        self_diagnostic_fault_in,
	input  wire logic        oscillator_start_failure_in,
	input  wire logic        config_check_error_in,
	input  wire logic        serial_frame_check_fault_in,
	input  wire logic        watchdog_fault_in,
	input  wire logic        reference_voltage_fault_in,
	input  wire logic        overtemperature_error_in,
	input  wire logic        overtemperature_warning_in,
	input  wire logic [7:0]  general_status_word_in,
	output logic [15:0]      reg_rdata_out,
	output logic             reg_rvalid_out,
	output logic             reg_error_out,
	output logic             break_command_mode_out,
	output logic             alarm_out,
	output logic             irq_out,
	output logic [1:0]       input_a_action_out,
	output logic             input_a_action_valid_out
);
	typedef struct packed {
		logic [15:0] input_a_limits;
		logic [15:0] input_b_limits;
		logic [15:0] die_temperature_limits;
		logic        mode;
		logic [15:0] alarm_fault_mask;
		logic [15:0] general_event_mask;
		logic [15:0] rdata;
		logic        rvalid;
		logic        error;
		logic        alarm;
		logic        irq;
		logic [1:0]  action;
		logic        action_valid;
		logic        prev_a_fault;
	} state_t;

	state_t      state;
	state_t      next_state;
	logic [15:0] alarm_status;
	logic [15:0] general_status;
	logic        alarm_summary;
	logic        general_summary;
	logic        port_ok;

	limit_check_if chan_a ();
	limit_check_if chan_b ();
	limit_check_if chan_t ();

	assign chan_a.limits       = state.input_a_limits;
	assign chan_a.result       = input_a_result_in;
	assign chan_a.result_valid = input_a_done_in; // R17
	assign chan_b.limits       = state.input_b_limits;
	assign chan_b.result       = input_b_result_in;
	assign chan_b.result_valid = input_b_done_in;
	assign chan_t.limits       = state.die_temperature_limits;
	assign chan_t.result       = temp_result_in;
	assign chan_t.result_valid = temp_done_in;

	window_check u_check_a (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.chk       (chan_a.checker_end)
	);
	window_check u_check_b (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.chk       (chan_b.checker_end)
	);
	window_check u_check_t (
		.clk_in    (clk_in),
		.resetn_in (resetn_in),
		.chk       (chan_t.checker_end)
	);

	// Status bits 14..0 show raw conditions regardless of mask; bit 15 is the other register's masked summary
	always_comb begin
		alarm_status = '0;
		alarm_status[limit_regs_pkg::BIT_SELF_DIAG]     =
			self_diagnostic_fault_in; // R9
		alarm_status[limit_regs_pkg::BIT_OSCILLATOR_START_FAILURE]      =
			oscillator_start_failure_in;
		alarm_status[limit_regs_pkg::BIT_CONFIG_CHECK]  =
			config_check_error_in; // R11
		alarm_status[limit_regs_pkg::BIT_FRAME_CHECK]   =
			serial_frame_check_fault_in;
		alarm_status[limit_regs_pkg::BIT_WATCHDOG]      = watchdog_fault_in;
		alarm_status[limit_regs_pkg::BIT_REFERENCE]     =
			reference_voltage_fault_in;
		alarm_status[limit_regs_pkg::BIT_INPUT_B]       = chan_b.fault;
		alarm_status[limit_regs_pkg::BIT_INPUT_A]       = chan_a.fault;
		alarm_status[limit_regs_pkg::BIT_TEMPERATURE]   = chan_t.fault;
		alarm_status[limit_regs_pkg::BIT_OVERTEMP_ERR]  =
			overtemperature_error_in; // R12
		alarm_status[limit_regs_pkg::BIT_OVERTEMP_WARN] =
			overtemperature_warning_in;
		general_status = {8'h00, general_status_word_in};
		alarm_summary   = |(alarm_status[14:0] &
			~state.alarm_fault_mask[14:0]); // R15 R8
		general_summary = |(general_status[7:0] &
			~state.general_event_mask[7:0]); // R13 R14
		alarm_status[limit_regs_pkg::BIT_ALARM_SUMMARY] = general_summary;
		general_status[limit_regs_pkg::BIT_GENERAL_SUMMARY] = alarm_summary;
	end

	// Break-port writes reach the map only in break mode and vice versa
	assign port_ok = (from_break_port_in == state.mode); // R6

	always_comb begin
		next_state = state;
		next_state.rvalid = 1'b0;
		next_state.error  = 1'b0;
		next_state.alarm  = alarm_summary; // R8
		next_state.irq    = alarm_summary | general_summary;
		next_state.prev_a_fault = chan_a.fault;
		next_state.action_valid = 1'b0;
		if (chan_a.fault && !state.prev_a_fault) begin
			next_state.action       = input_a_action_in; // R16
			next_state.action_valid = 1'b1;
		end
		if (reg_write_in) begin
			if (reg_addr_in == limit_regs_pkg::ADDR_INTERFACE_MODE) begin
				// Mode is writable only from the break port in any mode
				if (from_break_port_in) begin
					next_state.mode = reg_wdata_in[0]; // R7
				end else begin
					next_state.error = 1'b1;
				end
			end else if (!port_ok) begin
				next_state.error = 1'b1; // R6
			end else begin
				case (reg_addr_in)
				limit_regs_pkg::ADDR_INPUT_A_LIMITS:
					next_state.input_a_limits = reg_wdata_in;
				limit_regs_pkg::ADDR_INPUT_B_LIMITS:
					next_state.input_b_limits = reg_wdata_in;
				limit_regs_pkg::ADDR_DIE_TEMP_LIMITS:
					next_state.die_temperature_limits = reg_wdata_in;
				limit_regs_pkg::ADDR_ALARM_FAULT_MASK:
					next_state.alarm_fault_mask =
						(reg_wdata_in & limit_regs_pkg::ALARM_MASK_WRITABLE) |
						(limit_regs_pkg::ALARM_MASK_RESET &
						~limit_regs_pkg::ALARM_MASK_WRITABLE); // R11
				limit_regs_pkg::ADDR_GENERAL_MASK:
					next_state.general_event_mask =
						(reg_wdata_in & limit_regs_pkg::GENERAL_MASK_WRITABLE) |
						(limit_regs_pkg::GENERAL_MASK_RESET &
						~limit_regs_pkg::GENERAL_MASK_WRITABLE); // R14
				default:
					next_state.error = 1'b1;
				endcase
			end
		end else if (reg_read_in) begin
			next_state.rvalid = 1'b1;
			next_state.rdata  = 16'h0000;
			if (!port_ok &&
				reg_addr_in != limit_regs_pkg::ADDR_INTERFACE_MODE) begin
				next_state.error = 1'b1;
			end else begin
				case (reg_addr_in)
				limit_regs_pkg::ADDR_INPUT_A_LIMITS:
					next_state.rdata = state.input_a_limits;
				limit_regs_pkg::ADDR_INPUT_B_LIMITS:
					next_state.rdata = state.input_b_limits;
				limit_regs_pkg::ADDR_DIE_TEMP_LIMITS:
					next_state.rdata = state.die_temperature_limits;
				limit_regs_pkg::ADDR_INTERFACE_MODE:
					next_state.rdata = {15'h0000, state.mode};
				limit_regs_pkg::ADDR_ALARM_FAULT_MASK:
					next_state.rdata = state.alarm_fault_mask;
				limit_regs_pkg::ADDR_GENERAL_MASK:
					next_state.rdata = state.general_event_mask;
				limit_regs_pkg::ADDR_ALARM_STATUS:
					next_state.rdata = alarm_status; // R9
				limit_regs_pkg::ADDR_GENERAL_STATUS:
					next_state.rdata = general_status;
				default:
					next_state.error = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= '0;
			state.input_a_limits <= limit_regs_pkg::LIMITS_RESET; // R5
			state.input_b_limits <= limit_regs_pkg::LIMITS_RESET;
			state.die_temperature_limits <= limit_regs_pkg::LIMITS_RESET;
			state.mode <= limit_regs_pkg::MODE_RESET[0]; // R6
			state.alarm_fault_mask <= limit_regs_pkg::ALARM_MASK_RESET; // R10
			state.general_event_mask <=
				limit_regs_pkg::GENERAL_MASK_RESET; // R13
		end else begin
			state <= next_state;
		end
	end

	assign reg_rdata_out            = state.rdata;
	assign reg_rvalid_out           = state.rvalid;
	assign reg_error_out            = state.error;
	assign break_command_mode_out   = state.mode;
	assign alarm_out                = state.alarm;
	assign irq_out                  = state.irq;
	assign input_a_action_out       = state.action;
	assign input_a_action_valid_out = state.action_valid;

	// Refused writes must leave every register as it was
	a_mode_spi_write: assert property (@(posedge clk_in) // R7
		disable iff (!resetn_in)
		reg_write_in && !from_break_port_in &&
		reg_addr_in == 8'h16 |=> $stable(break_command_mode_out))
		else $error("mode written from SPI");
	a_mode_spi_error: assert property (@(posedge clk_in) // R7
		disable iff (!resetn_in)
		reg_write_in && !from_break_port_in &&
		reg_addr_in == 8'h16 |=> reg_error_out)
		else $error("mode write from SPI not refused");
	a_mode_break_write: assert property (@(posedge clk_in) // R6
		disable iff (!resetn_in)
		reg_write_in && from_break_port_in && reg_addr_in == 8'h16
		|=> break_command_mode_out == $past(reg_wdata_in[0]))
		else $error("mode not taken from break port");
	a_refused_write: assert property (@(posedge clk_in) // R6
		disable iff (!resetn_in)
		reg_write_in && !port_ok && reg_addr_in != 8'h16
		|=> reg_error_out && $stable(state.input_a_limits) &&
		$stable(state.alarm_fault_mask))
		else $error("write taken from the wrong port");
	a_read_answer: assert property (@(posedge clk_in) // R6
		disable iff (!resetn_in)
		reg_read_in && !reg_write_in |=> reg_rvalid_out)
		else $error("read not answered");
	a_limit_write: assert property (@(posedge clk_in) // R1
		disable iff (!resetn_in)
		reg_write_in && port_ok && reg_addr_in == 8'h12
		|=> state.input_a_limits == $past(reg_wdata_in))
		else $error("input A limits not written");
	a_alarm_mask_write: assert property (@(posedge clk_in) // R11
		disable iff (!resetn_in)
		reg_write_in && port_ok && reg_addr_in == 8'h1D
		|=> state.alarm_fault_mask[13:12] ==
		$past(reg_wdata_in[13:12]) &&
		state.alarm_fault_mask[8:0] == $past(reg_wdata_in[8:0]))
		else $error("alarm mask field not written");
	a_general_mask_write: assert property (@(posedge clk_in) // R13
		disable iff (!resetn_in)
		reg_write_in && port_ok && reg_addr_in == 8'h1E
		|=> state.general_event_mask[7:6] ==
		$past(reg_wdata_in[7:6]) &&
		state.general_event_mask[3:0] == $past(reg_wdata_in[3:0]))
		else $error("general mask field not written");
	a_alarm_masked: assert property (@(posedge clk_in) // R8
		disable iff (!resetn_in)
		((alarm_status[14:0] & ~state.alarm_fault_mask[14:0]) == 15'h0)
		|=> !alarm_out)
		else $error("alarm raised by masked fault");
	a_alarm_unmasked: assert property (@(posedge clk_in) // R15
		disable iff (!resetn_in)
		chan_a.fault && !state.alarm_fault_mask[3] |=> alarm_out && irq_out)
		else $error("unmasked input A fault lost");
	a_irq_general: assert property (@(posedge clk_in) // R8
		disable iff (!resetn_in)
		(general_status_word_in &
		~state.general_event_mask[7:0]) != 8'h00
		|=> irq_out)
		else $error("unmasked general event lost");
	a_irq_quiet: assert property (@(posedge clk_in) // R8
		disable iff (!resetn_in)
		(alarm_status[14:0] & ~state.alarm_fault_mask[14:0]) ==
		15'h0 && (general_status_word_in &
		~state.general_event_mask[7:0]) == 8'h00 |=> !irq_out)
		else $error("interrupt raised by masked event");
	a_reserved_alarm: assert property (@(posedge clk_in) // R11
		disable iff (!resetn_in)
		state.alarm_fault_mask[15:14] == 2'h3 &&
		state.alarm_fault_mask[11:9] == 3'h7)
		else $error("alarm mask reserved bits changed");
	a_reserved_general: assert property (@(posedge clk_in) // R14
		disable iff (!resetn_in)
		state.general_event_mask[15:8] == 8'hFF &&
		state.general_event_mask[5:4] == 2'h3)
		else $error("general mask reserved bits changed");
	a_status_read: assert property (@(posedge clk_in) // R9
		disable iff (!resetn_in)
		reg_read_in && !reg_write_in && port_ok && reg_addr_in == 8'h20
		|=> reg_rvalid_out && reg_rdata_out[3] == $past(chan_a.fault))
		else $error("status read ignores fault");
	a_status_others: assert property (@(posedge clk_in) // R9
		disable iff (!resetn_in)
		reg_read_in && !reg_write_in && port_ok && reg_addr_in == 8'h20
		|=> reg_rdata_out[4] == $past(chan_b.fault) &&
		reg_rdata_out[2] == $past(chan_t.fault))
		else $error("status read ignores input B or temperature");
	a_action_report: assert property (@(posedge clk_in) // R16
		disable iff (!resetn_in)
		chan_a.fault && !$past(chan_a.fault) |=> input_a_action_valid_out
		&& input_a_action_out == $past(input_a_action_in))
		else $error("input A action not reported");
	a_action_quiet: assert property (@(posedge clk_in) // R16
		disable iff (!resetn_in)
		!(chan_a.fault && !state.prev_a_fault)
		|=> !input_a_action_valid_out)
		else $error("input A action without a fault edge");
endmodule // adc_limit_and_fault_mask_regs
`default_nettype wire

// file: hw/limit_regs_pkg.sv
/*
 * Shared constants for the limit and fault mask register bank.
 * Assumes a 16-bit register word and 12-bit conversion results.
 */
package limit_regs_pkg;
	localparam logic [7:0]  ADDR_INPUT_A_LIMITS   = 8'h12;
	localparam logic [7:0]  ADDR_INPUT_B_LIMITS   = 8'h13;
	localparam logic [7:0]  ADDR_DIE_TEMP_LIMITS  = 8'h14;
	localparam logic [7:0]  ADDR_INTERFACE_MODE   = 8'h16;
	localparam logic [7:0]  ADDR_ALARM_FAULT_MASK = 8'h1D;
	localparam logic [7:0]  ADDR_GENERAL_MASK     = 8'h1E;
	localparam logic [7:0]  ADDR_ALARM_STATUS     = 8'h20;
	localparam logic [7:0]  ADDR_GENERAL_STATUS   = 8'h21;

	localparam logic [15:0] LIMITS_RESET          = 16'hFF00;
	localparam logic [15:0] MODE_RESET            = 16'h0000;
	localparam logic [15:0] ALARM_MASK_RESET      = 16'hEFDF;
	localparam logic [15:0] GENERAL_MASK_RESET    = 16'hFFFF;
	// Writable bits; the rest are reserved and hold their reset value
	localparam logic [15:0] ALARM_MASK_WRITABLE   = 16'h31FF;
	localparam logic [15:0] GENERAL_MASK_WRITABLE = 16'h00CF;

	localparam logic [3:0]  HIGH_FILL             = 4'hF;
	localparam logic [3:0]  LOW_FILL              = 4'h0;

	localparam int BIT_SELF_DIAG      = 13;
	localparam int BIT_OSCILLATOR_START_FAILURE       = 12;
	localparam int BIT_CONFIG_CHECK   = 8;
	localparam int BIT_FRAME_CHECK    = 7;
	localparam int BIT_WATCHDOG       = 6;
	localparam int BIT_REFERENCE      = 5;
	localparam int BIT_INPUT_B        = 4;
	localparam int BIT_INPUT_A        = 3;
	localparam int BIT_TEMPERATURE    = 2;
	localparam int BIT_OVERTEMP_ERR   = 1;
	localparam int BIT_OVERTEMP_WARN  = 0;
	localparam int BIT_ALARM_SUMMARY  = 15;
	localparam int BIT_GENERAL_SUMMARY = 15;

	localparam logic [1:0]  ACTION_NONE  = 2'h0;
	localparam logic [1:0]  ACTION_CLEAR = 2'h1;
	localparam logic [1:0]  ACTION_ALARM = 2'h2;
	localparam logic [1:0]  ACTION_HIZ   = 2'h3;
endpackage

// file: hw/limit_check_if.sv
/*
 * Carrier between the register bank and one window comparator.
 * Assumes both ends share clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
interface limit_check_if;
	logic [15:0] limits;
	logic [11:0] result;
	logic        result_valid;
	logic        fault;

	modport bank (output limits, output result, output result_valid,
		input fault);
	modport checker_end (input limits, input result, input result_valid,
		output fault);
endinterface
`default_nettype wire

// file: hw/window_check.sv
/*
 * Window comparator for one 12-bit conversion channel.
 * Assumes the result is stable in the cycle its valid strobe is high.
 */
`timescale 1ns/100ps
`default_nettype none
module window_check (
	input  wire logic           clk_in,
	input  wire logic           resetn_in,
	limit_check_if.checker_end  chk
);
	typedef struct packed {
		logic fault;
	} state_t;

	state_t      state;
	state_t      next_state;
	logic [11:0] high_bound;
	logic [11:0] low_bound;

	always_comb begin
		high_bound = {chk.limits[15:8], limit_regs_pkg::HIGH_FILL}; // R1
		low_bound  = {chk.limits[7:0], limit_regs_pkg::LOW_FILL};   // R2
		next_state = state;
		if (chk.result_valid) begin // R17
			next_state.fault = (chk.result > high_bound) ||
				(chk.result < low_bound); // R3 R4
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign chk.fault = state.fault;

	a_window_fault_set: assert property (@(posedge clk_in) // R1
		disable iff (!resetn_in)
		chk.result_valid |=> chk.fault == $past((chk.result >
		{chk.limits[15:8], 4'hF}) || (chk.result <
		{chk.limits[7:0], 4'h0})))
		else $error("window fault does not match result");
	a_window_fault_hold: assert property (@(posedge clk_in) // R17
		disable iff (!resetn_in)
		!chk.result_valid |=> $stable(chk.fault))
		else $error("window fault changed without a result");
endmodule // window_check
`default_nettype wire

// file: tb/host_port_model.sv
/*
 * Host controller model: issues one register access at a time.
 * Assumes the bank answers at the taking edge itself, with registered outputs.
 */
`timescale 1ns/100ps
`default_nettype none
module host_port_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] rdata_in,
	input  wire logic        rvalid_in,
	input  wire logic        error_in,
	output logic             write_out,
	output logic             read_out,
	output logic             break_out,
	output logic [7:0]       addr_out,
	output logic [15:0]      wdata_out
);
	initial begin
		write_out = 1'b0;
		read_out = 1'b0;
		break_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 16'h0000;
	end
	// Released address and data lines show the inverse so stale values never match
	task automatic access(input logic wr, input logic brk,
		input logic [7:0] a, input logic [15:0] d,
		output logic [15:0] rd, output logic err);
		@(posedge clk_in);
		#1;
		write_out = wr;
		read_out = !wr;
		break_out = brk;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		write_out = 1'b0;
		read_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
		rd = rvalid_in ? rdata_in : 16'hXXXX;
		err = error_in;
	endtask
endmodule // host_port_model
`default_nettype wire

// file: tb/adc_limit_and_fault_mask_regs_tb.sv
/*
 * Self-checking bench for the limit and fault mask register bank.
 * Assumes the host model drives the register strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module adc_limit_and_fault_mask_regs_tb;
	logic        clk_in, resetn_in, wr_s, rd_s, brk_s;
	logic [7:0]  addr, src, gen_word;
	logic [15:0] wdata, rdata;
	logic [11:0] res_a, res_b, res_t;
	logic        done_a, done_b, done_t, rvalid, rerr, mode;
	logic        alarm, irq, act_v;
	logic [1:0]  act_in, act;
	int          err_count, compares, cycles;
	int          pos [8] = '{13, 12, 8, 7, 6, 5, 1, 0};

	adc_limit_and_fault_mask_regs uut (.clk_in(clk_in),
		.resetn_in(resetn_in), .reg_write_in(wr_s), .reg_read_in(rd_s),
		.from_break_port_in(brk_s), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .input_a_result_in(res_a),
		.input_a_done_in(done_a), .input_b_result_in(res_b),
		.input_b_done_in(done_b), .temp_result_in(res_t),
		.temp_done_in(done_t), .input_a_action_in(act_in),
		.self_diagnostic_fault_in(src[7]),
		.oscillator_start_failure_in(src[6]),
		.config_check_error_in(src[5]),
		.serial_frame_check_fault_in(src[4]),
		.watchdog_fault_in(src[3]), .reference_voltage_fault_in(src[2]),
		.overtemperature_error_in(src[1]),
		.overtemperature_warning_in(src[0]),
		.general_status_word_in(gen_word), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .reg_error_out(rerr),
		.break_command_mode_out(mode), .alarm_out(alarm), .irq_out(irq),
		.input_a_action_out(act), .input_a_action_valid_out(act_v));
	host_port_model host (.clk_in(clk_in), .rdata_in(rdata),
		.rvalid_in(rvalid), .error_in(rerr), .write_out(wr_s),
		.read_out(rd_s), .break_out(brk_s), .addr_out(addr),
		.wdata_out(wdata));

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input logic brk, input logic ee);
		logic [15:0] r;
		logic        e;
		host.access(1'b1, brk, a, d, r, e);
		chk("write error", {15'h0000, ee}, {15'h0000, e});
	endtask

	task automatic rd(input logic [7:0] a, input logic brk,
		input logic [15:0] x, input logic ee);
		logic [15:0] r;
		logic        e;
		host.access(1'b0, brk, a, 16'h0000, r, e);
		chk("read error", {15'h0000, ee}, {15'h0000, e});
		chk("read data", x, r);
	endtask

	task automatic drive(input int ch, input logic [11:0] v);
		@(posedge clk_in);
		#1;
		res_a = v;
		res_b = v;
		res_t = v;
		done_a = (ch == 0);
		done_b = (ch == 1);
		done_t = (ch == 2);
		@(posedge clk_in);
		#1;
		{done_a, done_b, done_t} = 3'h0;
	endtask

	task automatic t_reset();
		logic [7:0]  a [6] = '{8'h12, 8'h13, 8'h14, 8'h16, 8'h1D, 8'h1E};
		logic [15:0] v [6] = '{16'hFF00, 16'hFF00, 16'hFF00, 16'h0000,
			16'hEFDF, 16'hFFFF};
		for (int i = 0; i < 6; i++)
			rd(a[i], 1'b0, v[i], 1'b0);
		rd(8'h15, 1'b0, 16'h0000, 1'b1);
		chk("mode", 16'h0000, {15'h0000, mode});
	endtask

	task automatic t_mode();
		wr(8'h16, 16'h0001, 1'b0, 1'b1);
		chk("mode", 16'h0000, {15'h0000, mode});
		wr(8'h16, 16'h0001, 1'b1, 1'b0);
		chk("mode", 16'h0001, {15'h0000, mode});
		rd(8'h12, 1'b0, 16'h0000, 1'b1);
		rd(8'h12, 1'b1, 16'hFF00, 1'b0);
		wr(8'h16, 16'h0000, 1'b1, 1'b0);
		rd(8'h13, 1'b0, 16'hFF00, 1'b0);
	endtask

	task automatic t_masks();
		logic [15:0] ra, rg, wa, wg;
		ra = limit_regs_pkg::ALARM_MASK_RESET;
		rg = limit_regs_pkg::GENERAL_MASK_RESET;
		wa = limit_regs_pkg::ALARM_MASK_WRITABLE;
		wg = limit_regs_pkg::GENERAL_MASK_WRITABLE;
		wr(8'h1D, 16'h0000, 1'b0, 1'b0);
		rd(8'h1D, 1'b0, ra & ~wa, 1'b0);
		wr(8'h1E, 16'h0000, 1'b0, 1'b0);
		rd(8'h1E, 1'b0, rg & ~wg, 1'b0);
		wr(8'h1D, ra, 1'b0, 1'b0);
		wr(8'h1E, rg, 1'b0, 1'b0);
		rd(8'h1E, 1'b0, 16'hFFFF, 1'b0);
	endtask

	task automatic t_sources();
		for (int i = 0; i < 8; i++) begin
			src = 8'h80 >> i;
			repeat (3) @(posedge clk_in);
			rd(8'h20, 1'b0, 16'h0001 << pos[i], 1'b0);
			chk("alarm", {15'h0000, pos[i] == 12 || pos[i] == 5},
				{15'h0000, alarm});
		end
		src = 8'h00;
	endtask

	task automatic t_window();
		logic [11:0] v [4] = '{12'h80F, 12'h810, 12'h100, 12'h0FF};
		int          b [3] = '{3, 4, 2};
		for (int c = 0; c < 3; c++) begin
			wr(8'h12 + c[7:0], 16'h8010, 1'b0, 1'b0);
			for (int k = 0; k < 4; k++) begin
				drive(c, v[k]);
				repeat (2) @(posedge clk_in);
				rd(8'h20, 1'b0, k[0] ? 16'h0001 << b[c] : 16'h0000,
					1'b0);
				chk("alarm", 16'h0000, {15'h0000, alarm});
			end
			wr(8'h12 + c[7:0], 16'hFF00, 1'b0, 1'b0);
			// Fault holds until the next result; clear it for later reads
			drive(c, 12'h800);
		end
	endtask

	task automatic t_alarm();
		wr(8'h12, 16'h8010, 1'b0, 1'b0);
		wr(8'h1D, 16'hEFD7, 1'b0, 1'b0);
		for (int c = 0; c < 4; c++) begin
			act_in = c[1:0];
			drive(0, 12'h400);
			drive(0, 12'h810);
			@(posedge clk_in);
			#1;
			chk("action valid", 16'h0001, {15'h0000, act_v});
			chk("action", {14'h0000, c[1:0]}, {14'h0000, act});
			chk("alarm", 16'h0001, {15'h0000, alarm});
			chk("irq", 16'h0001, {15'h0000, irq});
		end
		drive(0, 12'h400);
		wr(8'h1E, 16'hFFFE, 1'b0, 1'b0);
		gen_word = 8'h01;
		repeat (3) @(posedge clk_in);
		chk("alarm", 16'h0000, {15'h0000, alarm});
		chk("irq", 16'h0001, {15'h0000, irq});
		rd(8'h20, 1'b0, 16'h8000, 1'b0);
		rd(8'h21, 1'b0, 16'h0001, 1'b0);
	endtask

	initial begin
		{err_count, compares, cycles} = '0;
		resetn_in = 1'b0;
		{src, gen_word, act_in} = '0;
		{res_a, res_b, res_t} = '0;
		{done_a, done_b, done_t} = 3'h0;
		repeat (8) @(posedge clk_in);
		#1;
		resetn_in = 1'b1;
		t_reset();
		t_mode();
		t_masks();
		t_sources();
		t_window();
		t_alarm();
		complete_run();
	end
endmodule // adc_limit_and_fault_mask_regs_tb
`default_nettype wire
